// [dv/fic_link_checker.sv]
// Checker for the serial link between host end and device end
`timescale 1ns/100ps
module fic_link_checker (
	input wire logic clk, // Clock
	input wire logic nrst, // Reset, active low
	input wire logic cs_n, // Select
	input wire logic sclk, // Serial clock
	input wire logic mosi, // Host data
	input wire logic miso_o, // Device data
	input wire logic miso_oe, // Device drive enable
	input wire logic miso, // Resolved device line
	input wire logic busy // Write cycle running
);
	// ==========================================================
	// Frame tracking
	logic sclk_q;
	logic [5:0] bits_q, bits_d;
	logic [7:0] op_q, op_d;
	logic [5:0] hi_q, hi_d;
	wire sclk_rise = sclk & ~sclk_q;
	// Opcodes with address or dummy bytes need 32 bits before output
	wire [5:0] need = (op_q == 8'hAB || op_q == 8'h90) ? 6'h20 : 6'h08;
	assign bits_d = cs_n ? 6'h00 : (sclk_rise && bits_q != 6'h3f) ? bits_q + 6'h01 : bits_q;
	assign op_d = (!cs_n && sclk_rise && bits_q < 6'h08) ? {op_q[6:0], mosi} : op_q;
	assign hi_d = !cs_n ? 6'h00 : (hi_q == 6'h3f) ? hi_q : hi_q + 6'h01;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sclk_q <= 1'b0;
			bits_q <= 6'h00;
			op_q <= 8'h00;
			hi_q <= 6'h00;
		end else begin
			sclk_q <= sclk;
			bits_q <= bits_d;
			op_q <= op_d;
			hi_q <= hi_d;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// ==========================================================
	// Assertions
	AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
		else $error("serial clock moves while select is high");
	AST_MOSI_HOLD: assert property (sclk |-> $stable(mosi))
		else $error("host data changes while serial clock is high");
	AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk[*8] ##1 sclk ##1 sclk ##1 !sclk)
		else $error("serial clock high phase is not ten cycles");
	AST_MISO_ON_LOW: assert property (miso_oe && $changed(miso_o) |-> !sclk)
		else $error("device data changes while serial clock is high");
	AST_OE_AFTER_CMD: assert property ($rose(miso_oe) |-> bits_q >= need)
		else $error("device drives before the command bits are complete");
	AST_OE_RELEASE: assert property ($rose(cs_n) |-> ##[1:6] !miso_oe)
		else $error("device output not released after select rises");
	AST_OE_IDLE: assert property (cs_n [*8] |-> !miso_oe)
		else $error("device drives while deselected");
	AST_BUSY_QUIET: assert property (busy |-> !$rose(miso_oe))
		else $error("device answers while busy");
	AST_GAP_MIN: assert property ($fell(cs_n) |-> hi_q >= 6'h0A)
		else $error("select gap shorter than ten cycles");
	AST_WAKE_GAP: assert property ($fell(cs_n) && op_q == 8'hAB |-> hi_q >= 6'h19)
		else $error("select low before the release wait ends");

	cover property ($rose(miso_oe) && op_q == 8'h9F);
	cover property ($rose(miso_oe) && op_q == 8'h90);
	cover property ($rose(miso_oe) && op_q == 8'hAB);
	cover property (miso_oe && !miso);
endmodule

// [dv/flash_id_and_wake_commands_bench.sv]
// Self-checking bench joining the host end and the device end
`timescale 1ns/100ps
module flash_id_and_wake_commands_bench import fic_pkg::*;;
	localparam logic [7:0] MFR = 8'hC3; // Arbitrary value
	localparam logic [7:0] DEV = 8'h21; // Arbitrary value
	localparam logic [7:0] MT = 8'h40; // Arbitrary value
	localparam logic [7:0] CAP = 8'h15; // Arbitrary value
	localparam int PUW = 300;
	logic clk, nrst, busy, pd_req, cmd_valid, cmd_addr_lsb;
	fic_cmd_t cmd;
	logic [2:0] cmd_nbytes;
	logic in_pd, wake_busy, ready, rx_valid, done, write_ok;
	logic [7:0] rx_data;
	logic [7:0] rx_q [8];
	int n_rx, t_rdy, n_mismatch, n_checks;

	fic_link_if lk();
	fic_flash_dev #(.MFR_CODE(MFR), .DEV_CODE(DEV), .MEM_TYPE(MT), .CAPACITY(CAP))
		fic_flash_dev_inst (.clk(clk), .nrst(nrst), .link(lk), .busy(busy), .pd_req(pd_req),
		.in_pd(in_pd), .wake_busy(wake_busy));
	fic_id_host #(.PUW_CYCLES(PUW)) fic_id_host_inst (.clk(clk), .nrst(nrst), .link(lk),
		.cmd_valid(cmd_valid), .cmd(cmd), .cmd_addr_lsb(cmd_addr_lsb), .cmd_nbytes(cmd_nbytes),
		.ready(ready), .rx_valid(rx_valid), .rx_data(rx_data), .done(done), .write_ok(write_ok));
	fic_link_checker fic_link_checker_inst (.clk(clk), .nrst(nrst), .cs_n(lk.cs_n),
		.sclk(lk.sclk), .mosi(lk.mosi), .miso_o(lk.miso_o), .miso_oe(lk.miso_oe),
		.miso(lk.miso), .busy(busy));

	// ==========================================================
	// Reporting
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_bit(input string nm, input logic e, input logic g);
		chk_byte(nm, {7'h00, e}, {7'h00, g});
	endtask

	// Expected bytes packed first byte highest
	task automatic chk_frame(input string nm, input logic [31:0] e, input int n);
		chk_byte({nm, "_count"}, 8'(n), 8'(n_rx));
		for (int i = 0; i < n; i++) begin
			chk_byte(nm, e[8*(n-1-i) +: 8], rx_q[i]);
		end
		$display("test %s ended", nm);
	endtask

	// ==========================================================
	// Command port access, called at a falling edge
	task automatic run_cmd(input fic_cmd_t c, input logic lsb, input logic [2:0] nb);
		int t;
		t = 0;
		while (ready !== 1'b1 && t < 3000) begin
			@(negedge clk);
			t++;
		end
		chk_bit("cmd_ready", 1'b1, ready);
		cmd = c;
		cmd_addr_lsb = lsb;
		cmd_nbytes = nb;
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
		n_rx = 0;
		t = 0;
		do begin
			@(negedge clk);
			if (rx_valid === 1'b1 && n_rx < 8) begin
				rx_q[n_rx] = rx_data;
				n_rx++;
			end
			t++;
		end while (done !== 1'b1 && t < 3000);
		chk_bit("frame_done", 1'b1, done);
	endtask

	task automatic enter_pd;
		pd_req = 1'b1;
		@(negedge clk);
		pd_req = 1'b0;
		repeat (2) @(negedge clk);
		chk_bit("pd_entry", 1'b1, in_pd);
	endtask

	// ==========================================================
	// Clock, watchdog, tests
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		// About a dozen frames of under two thousand cycles each
		repeat (60000) @(posedge clk);
		n_mismatch++;
		$display("MISMATCH watchdog expected finish seen timeout");
		conclude;
	end

	initial begin
		n_mismatch = 0;
		n_checks = 0;
		nrst = 1'b0;
		busy = 1'b0;
		pd_req = 1'b0;
		cmd_valid = 1'b0;
		cmd = FIC_CMD_WAKE;
		cmd_addr_lsb = 1'b0;
		cmd_nbytes = 3'h0;
		repeat (6) @(negedge clk);
		nrst = 1'b1;
		t_rdy = 0;
		while (ready !== 1'b1 && t_rdy < 1000) begin
			@(negedge clk);
			t_rdy++;
		end
		chk_bit("first_ready", 1'b1, ready);
		chk_bit("first_ready_late", 1'b1, t_rdy >= 250);
		chk_bit("write_ok_early", 1'b0, write_ok);
		$display("test power_up ended");
		run_cmd(FIC_CMD_JEDEC_ID, 1'b0, 3'h4);
		chk_frame("jedec", {MFR, MT, CAP, MFR}, 4);
		run_cmd(FIC_CMD_MFR_ID, 1'b0, 3'h3);
		chk_frame("mfr_addr0", {8'h00, MFR, DEV, MFR}, 3);
		run_cmd(FIC_CMD_MFR_ID, 1'b1, 3'h3);
		chk_frame("mfr_addr1", {8'h00, DEV, MFR, DEV}, 3);
		run_cmd(FIC_CMD_DEV_ID, 1'b0, 3'h3);
		chk_frame("dev_id", {8'h00, DEV, DEV, DEV}, 3);
		chk_bit("write_ok_late", 1'b1, write_ok);
		// Released line floats high, so an ignored read yields all ones
		busy = 1'b1;
		run_cmd(FIC_CMD_DEV_ID, 1'b0, 3'h1);
		chk_frame("busy_dev_id", 32'h0000_00FF, 1);
		run_cmd(FIC_CMD_JEDEC_ID, 1'b0, 3'h1);
		chk_frame("busy_jedec", 32'h0000_00FF, 1);
		busy = 1'b0;
		chk_bit("awake", 1'b0, in_pd);
		// Release opcode while awake must start no wait
		run_cmd(FIC_CMD_WAKE, 1'b0, 3'h0);
		repeat (8) @(negedge clk);
		chk_bit("awake_no_wait", 1'b0, wake_busy);
		$display("test awake_release ended");
		enter_pd;
		run_cmd(FIC_CMD_JEDEC_ID, 1'b0, 3'h1);
		chk_frame("pd_jedec", 32'h0000_00FF, 1);
		run_cmd(FIC_CMD_WAKE, 1'b0, 3'h0);
		chk_bit("wake_pending", 1'b1, in_pd);
		repeat (8) @(negedge clk);
		chk_bit("wake_wait", 1'b1, wake_busy);
		repeat (40) @(negedge clk);
		chk_bit("wake_short", 1'b0, in_pd);
		$display("test wake_only ended");
		enter_pd;
		run_cmd(FIC_CMD_DEV_ID, 1'b0, 3'h1);
		chk_frame("pd_dev_id", {24'h00_0000, DEV}, 1);
		repeat (35) @(negedge clk);
		chk_bit("wake_long_hold", 1'b1, in_pd);
		repeat (40) @(negedge clk);
		chk_bit("wake_long_end", 1'b0, in_pd);
		run_cmd(FIC_CMD_JEDEC_ID, 1'b0, 3'h3);
		chk_frame("after_wake", {8'h00, MFR, MT, CAP}, 3);
		conclude;
	end
endmodule

// [verilog/fic_flash_dev.sv]
// Device end: wake and identification command handling of the serial flash
`timescale 1ns/100ps
`include "fic_params.svh"

// Function
// RQ1 - Wake-only AB frame resumes after short wait
// RQ2 - Host keeps select high during short wait
// RQ3 - AB plus three dummies returns device ID
// RQ4 - Device ID repeats until select rises
// RQ5 - Ident read from power-down waits longer
// RQ6 - Busy flag set: wake/ID opcodes ignored
// RQ7 - 90h address zero: manufacturer then device
// RQ8 - 90h address one: device then manufacturer
// RQ9 - 90h codes alternate while clocking continues
// RQ10 - 9Fh gives manufacturer, type, capacity
// RQ11 - Host waits write delay after power-up
// RQ12 - Host waits before first select low
// RQ13 - Power-down accepts only the release opcode
// RQ14 - Sample on rising edge, abandon partials
// RQ15 - Drive output only while shifting IDs
module fic_flash_dev import fic_pkg::*; #(
	parameter logic [7:0] MFR_CODE = 8'h5A, // Arbitrary value
	parameter logic [7:0] DEV_CODE = 8'h13, // Arbitrary value
	parameter logic [7:0] MEM_TYPE = 8'h30, // Arbitrary value
	parameter logic [7:0] CAPACITY = 8'h14 // Arbitrary value
) (
	input wire logic clk, // 25 MHz clock
	input wire logic nrst, // Async reset, active low
	fic_link_if.dev link, // Serial link pins
	input wire logic busy, // Erase/program/write running
	input wire logic pd_req, // Pulse: enter power-down
	output logic in_pd, // Power-down state
	output logic wake_busy // Release wait running
);

	// ==========================================================
	// Pin synchronisers, bit 0 select, 1 clock, 2 data
	// Reset to idle pin levels so no false clock edge follows reset
	logic [2:0] sync0_q, sync1_q, sync2_q, filt_q;
	wire [2:0] agree = ~(sync1_q ^ sync2_q);
	wire [2:0] filt_d = (agree & sync2_q) | (~agree & filt_q);
	wire cs_rise = filt_d[0] & ~filt_q[0];
	wire cs_fall = ~filt_d[0] & filt_q[0];
	wire sck_rise = filt_d[1] & ~filt_q[1] & ~filt_q[0];
	wire sck_fall = ~filt_d[1] & filt_q[1] & ~filt_q[0];
	wire din = filt_d[2];

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync0_q <= 3'b001;
			sync1_q <= 3'b001;
			sync2_q <= 3'b001;
			filt_q <= 3'b001;
		end else begin
			sync0_q <= {link.mosi, link.sclk, link.cs_n};
			sync1_q <= sync0_q;
			sync2_q <= sync1_q;
			filt_q <= filt_d;
		end
	end

	// ==========================================================
	// Identification byte selection
	// Byte at position idx of the repeating answer of each mode
	function automatic logic [7:0] id_byte(input fic_mode_t m, input logic [1:0] idx);
		logic [7:0] b;
		b = DEV_CODE;
		case (m)
			FIC_MODE_DEV_ID: b = DEV_CODE;
			FIC_MODE_MFR_ID: b = idx[0] ? DEV_CODE : MFR_CODE;
			FIC_MODE_JEDEC_ID: b = (idx == 2'd0) ? MFR_CODE :
				((idx == 2'd1) ? MEM_TYPE : CAPACITY);
			default: b = DEV_CODE;
		endcase
		return b;
	endfunction

	// Advances once per finished byte; each mode has its own cycle
	function automatic logic [1:0] next_idx(input fic_mode_t m, input logic [1:0] idx);
		logic [1:0] n;
		n = 2'd0;
		case (m)
			FIC_MODE_DEV_ID: n = 2'd0; // RQ4
			FIC_MODE_MFR_ID: n = {1'b0, ~idx[0]}; // RQ9
			FIC_MODE_JEDEC_ID: n = (idx == 2'd2) ? 2'd0 : idx + 2'd1; // RQ10
			default: n = 2'd0;
		endcase
		return n;
	endfunction

	// ==========================================================
	// Command state
	fic_dev_state_t state_q;
	fic_mode_t mode_q;
	logic [7:0] op_q;
	// Counts opcode bits, then address or dummy bits
	logic [4:0] bit_cnt_q;
	logic [2:0] out_bit_q;
	logic [1:0] idx_q;
	logic [7:0] wait_cnt_q;
	logic in_pd_q, wake_busy_q, miso_q, oe_q;

	wire [7:0] op_full = {op_q[6:0], din};
	wire waiting = (wait_cnt_q != 8'd0);
	wire is_release = (op_full == `FIC_OP_RELEASE);
	wire is_mfr = (op_full == `FIC_OP_MFR_ID);
	wire is_jedec = (op_full == `FIC_OP_JEDEC_ID);
	// Busy blocks every opcode; power-down blocks everything but the release opcode
	wire op_ok = !busy && // RQ6
		(is_release || (!in_pd_q && (is_mfr || is_jedec))); // RQ13
	wire op_done = (state_q == FIC_DS_OPCODE) && sck_rise && (bit_cnt_q == 5'd7);
	wire addr_done = (state_q == FIC_DS_ADDR) && sck_rise &&
		(bit_cnt_q == 5'(`FIC_ADDR_BITS - 1));
	// Wake-only: select rises right after the opcode
	wire wake_only = (state_q == FIC_DS_ADDR) && (mode_q == FIC_MODE_DEV_ID) &&
		(bit_cnt_q == 5'd0);
	wire ident_end = (state_q == FIC_DS_SHIFT) && (mode_q == FIC_MODE_DEV_ID);
	wire [7:0] cur_byte = id_byte(mode_q, idx_q);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= FIC_DS_IDLE;
			mode_q <= FIC_MODE_DEV_ID;
			op_q <= 8'h00;
			bit_cnt_q <= 5'd0;
			idx_q <= 2'd0;
		end else if (cs_rise) begin
			// Select rising wins over all, so a cut frame is abandoned
			state_q <= FIC_DS_IDLE; // RQ14
		end else if (cs_fall) begin
			// A frame opened inside a release wait is dropped whole
			state_q <= waiting ? FIC_DS_IGNORE : FIC_DS_OPCODE; // RQ2
			bit_cnt_q <= 5'd0;
		end else if (op_done) begin
			bit_cnt_q <= 5'd0;
			idx_q <= 2'd0;
			if (!op_ok) begin
				state_q <= FIC_DS_IGNORE;
			end else if (is_jedec) begin
				state_q <= FIC_DS_SHIFT; // RQ10
				mode_q <= FIC_MODE_JEDEC_ID;
			end else begin
				state_q <= FIC_DS_ADDR; // RQ3 RQ7
				mode_q <= is_mfr ? FIC_MODE_MFR_ID : FIC_MODE_DEV_ID;
			end
		end else if (addr_done) begin
			state_q <= FIC_DS_SHIFT;
			// Address bit 0 picks the first code
			idx_q <= (mode_q == FIC_MODE_MFR_ID) ? {1'b0, din} : 2'd0; // RQ8
		end else if (sck_rise && (state_q == FIC_DS_OPCODE || state_q == FIC_DS_ADDR)) begin
			op_q <= op_full; // RQ14
			bit_cnt_q <= bit_cnt_q + 5'd1;
		end else if (sck_fall && state_q == FIC_DS_SHIFT && out_bit_q == 3'd7) begin
			idx_q <= next_idx(mode_q, idx_q);
		end
	end

	// ==========================================================
	// Serial output, changes on falling clock edges, MSB first
	// Output lags the pin edge by four cycles, so the host's half
	// period must stay well above eight cycles for its sample to settle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			miso_q <= 1'b0;
			oe_q <= 1'b0;
			out_bit_q <= 3'd0;
		end else if (cs_rise || cs_fall || state_q != FIC_DS_SHIFT) begin
			oe_q <= 1'b0; // RQ15
			out_bit_q <= 3'd0;
		end else if (sck_fall) begin
			miso_q <= cur_byte[3'd7 - out_bit_q]; // RQ3 RQ7 RQ10
			oe_q <= 1'b1; // RQ15
			out_bit_q <= out_bit_q + 3'd1;
		end
	end

	// ==========================================================
	// Power-down and release waits
	// A running wait wins over pd_req: entry then needs a new request
	// Long wait once the dummy bytes are in, however few ID bits follow; cuts inside the dummies start none
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			in_pd_q <= 1'b0;
			wait_cnt_q <= 8'd0;
			wake_busy_q <= 1'b0;
		end else begin
			wake_busy_q <= waiting;
			if (cs_rise && in_pd_q && !waiting && wake_only) begin
				wait_cnt_q <= 8'(`FIC_RELEASE_WAIT_SHORT_CYC); // RQ1
			end else if (cs_rise && in_pd_q && !waiting && ident_end) begin
				wait_cnt_q <= 8'(`FIC_RELEASE_WAIT_WITH_IDENT_CYC); // RQ5
			end else if (waiting) begin
				wait_cnt_q <= wait_cnt_q - 8'd1;
				if (wait_cnt_q == 8'd1) begin
					in_pd_q <= 1'b0; // RQ1 RQ5
				end
			end else if (pd_req) begin
				in_pd_q <= 1'b1;
			end
		end
	end

	// Outputs straight from flip-flops; wake_busy trails the counter by one
	assign in_pd = in_pd_q;
	assign wake_busy = wake_busy_q;
	assign link.miso_o = miso_q;
	assign link.miso_oe = oe_q;

endmodule

// [verilog/fic_id_host.sv]
// Host end: issues wake and identification frames and collects the answer
`timescale 1ns/100ps
`include "fic_params.svh"

module fic_id_host import fic_pkg::*; #(
	parameter int PUW_CYCLES = `FIC_POWERUP_WRITE_DELAY_CYC // Power-up write delay
) (
	input wire logic clk, // 25 MHz clock
	input wire logic nrst, // Async reset, active low
	fic_link_if.host link, // Serial link pins
	input wire logic cmd_valid, // Command request
	input wire fic_cmd_t cmd, // Command kind
	input wire logic cmd_addr_lsb, // 90h address bit 0
	input wire logic [2:0] cmd_nbytes, // Bytes to read
	output logic ready, // Idle, may take command
	output logic rx_valid, // Pulse: byte received
	output logic [7:0] rx_data, // Received byte
	output logic done, // Pulse: frame ended
	output logic write_ok // Write instructions allowed
);

	// ==========================================================
	// Miso synchroniser and filter
	logic miso0_q, miso1_q, miso2_q, miso_f_q;
	wire miso_f_d = (miso1_q == miso2_q) ? miso2_q : miso_f_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			miso0_q <= 1'b1;
			miso1_q <= 1'b1;
			miso2_q <= 1'b1;
			miso_f_q <= 1'b1;
		end else begin
			miso0_q <= link.miso;
			miso1_q <= miso0_q;
			miso2_q <= miso1_q;
			miso_f_q <= miso_f_d;
		end
	end

	// ==========================================================
	// Power-up delays
	logic [17:0] pu_cnt_q;
	wire pu_sel_ok = (pu_cnt_q >= 18'(`FIC_SUPPLY_TO_SELECT_DELAY_CYC)); // RQ12
	wire pu_wr_ok = (pu_cnt_q >= 18'(PUW_CYCLES)); // RQ11

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pu_cnt_q <= 18'd0;
		end else if (!pu_wr_ok || !pu_sel_ok) begin
			pu_cnt_q <= pu_cnt_q + 18'd1;
		end
	end

	// ==========================================================
	// Frame sequencer
	fic_host_state_t state_q;
	fic_cmd_t cmd_q;
	logic [4:0] div_q;
	logic [31:0] tx_q;
	logic [6:0] bit_cnt_q, cmd_bits_q, total_q;
	logic [7:0] rx_q, rx_data_q;
	logic [7:0] gap_q;
	logic cs_n_q, sclk_q, mosi_q, ready_q, rx_valid_q, done_q, write_ok_q;

	wire tick = (div_q == 5'(`FIC_SCK_HALF - 1));
	wire take = ready_q && cmd_valid;
	wire has_addr = (cmd == FIC_CMD_DEV_ID) || (cmd == FIC_CMD_MFR_ID);
	wire [6:0] new_cmd_bits = has_addr ? 7'(`FIC_OP_BITS + `FIC_ADDR_BITS) : 7'(`FIC_OP_BITS);
	wire [6:0] new_rd_bits = (cmd == FIC_CMD_WAKE) ? 7'd0 : {1'b0, cmd_nbytes, 3'b000};
	wire [7:0] new_op = (cmd == FIC_CMD_MFR_ID) ? `FIC_OP_MFR_ID :
		((cmd == FIC_CMD_JEDEC_ID) ? `FIC_OP_JEDEC_ID : `FIC_OP_RELEASE);
	wire in_read = (bit_cnt_q >= cmd_bits_q);
	wire [6:0] rd_pos = bit_cnt_q - cmd_bits_q;
	wire [7:0] rx_d = {rx_q[6:0], miso_f_q};
	// Release waits apply after every wake or device ID frame
	wire [7:0] gap_len = (cmd_q == FIC_CMD_WAKE) ? 8'(`FIC_RELEASE_WAIT_SHORT_CYC) :
		((cmd_q == FIC_CMD_DEV_ID) ? 8'(`FIC_RELEASE_WAIT_WITH_IDENT_CYC) :
		8'(`FIC_SCK_HALF));

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			div_q <= 5'd0;
		end else if (state_q == FIC_HS_IDLE || tick) begin
			div_q <= 5'd0;
		end else begin
			div_q <= div_q + 5'd1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= FIC_HS_POWERUP;
			cmd_q <= FIC_CMD_WAKE;
			tx_q <= 32'h0000_0000;
			bit_cnt_q <= 7'd0;
			cmd_bits_q <= 7'd0;
			total_q <= 7'd0;
			rx_q <= 8'h00;
			rx_data_q <= 8'h00;
			gap_q <= 8'd0;
			cs_n_q <= 1'b1;
			sclk_q <= 1'b0;
			mosi_q <= 1'b0;
			ready_q <= 1'b0;
			rx_valid_q <= 1'b0;
			done_q <= 1'b0;
			write_ok_q <= 1'b0;
		end else begin
			rx_valid_q <= 1'b0;
			done_q <= 1'b0;
			write_ok_q <= pu_wr_ok;
			case (state_q)
				FIC_HS_POWERUP: begin
					if (pu_sel_ok) begin
						state_q <= FIC_HS_IDLE; // RQ12
						ready_q <= 1'b1;
					end
				end
				FIC_HS_IDLE: begin
					if (take) begin
						state_q <= FIC_HS_LEAD;
						ready_q <= 1'b0;
						cmd_q <= cmd;
						cs_n_q <= 1'b0;
						tx_q <= {new_op, 23'h00_0000, (cmd == FIC_CMD_MFR_ID) & cmd_addr_lsb};
						mosi_q <= new_op[7];
						cmd_bits_q <= new_cmd_bits;
						total_q <= new_cmd_bits + new_rd_bits;
						bit_cnt_q <= 7'd0;
					end
				end
				FIC_HS_LEAD: begin
					if (tick) begin
						state_q <= FIC_HS_XFER;
					end
				end
				FIC_HS_XFER: begin
					if (tick && !sclk_q) begin
						sclk_q <= 1'b1;
						bit_cnt_q <= bit_cnt_q + 7'd1;
						if (in_read) begin
							rx_q <= rx_d;
							if (rd_pos[2:0] == 3'd7) begin
								rx_data_q <= rx_d;
								rx_valid_q <= 1'b1;
							end
						end
					end else if (tick) begin
						sclk_q <= 1'b0;
						if (bit_cnt_q == total_q) begin
							state_q <= FIC_HS_TAIL;
						end else begin
							mosi_q <= tx_q[30];
							tx_q <= {tx_q[30:0], 1'b0};
						end
					end
				end
				FIC_HS_TAIL: begin
					if (tick) begin
						state_q <= FIC_HS_GAP;
						cs_n_q <= 1'b1;
						mosi_q <= 1'b0;
						done_q <= 1'b1;
						gap_q <= gap_len; // RQ2 RQ5
					end
				end
				FIC_HS_GAP: begin
					if (gap_q <= 8'd1) begin
						state_q <= FIC_HS_IDLE;
						ready_q <= 1'b1;
					end else begin
						gap_q <= gap_q - 8'd1;
					end
				end
				default: begin
					state_q <= FIC_HS_IDLE;
				end
			endcase
		end
	end

	assign link.cs_n = cs_n_q;
	assign link.sclk = sclk_q;
	assign link.mosi = mosi_q;
	assign ready = ready_q;
	assign rx_valid = rx_valid_q;
	assign rx_data = rx_data_q;
	assign done = done_q;
	assign write_ok = write_ok_q;

endmodule

// [verilog/fic_link_if.sv]
// Serial link between the identification host and the flash device end
`timescale 1ns/100ps
interface fic_link_if;
	logic cs_n;
	logic sclk;
	logic mosi;
	logic miso_o;
	logic miso_oe;
	logic miso;

	// Released output floats high through a pull-up
	assign miso = miso_oe ? miso_o : 1'b1;

	modport dev (input cs_n, input sclk, input mosi, output miso_o, output miso_oe);
	modport host (output cs_n, output sclk, output mosi, input miso);
endinterface

// [verilog/fic_params.svh]
// Opcodes, timing figures and cycle counts shared by both link ends
`ifndef FIC_PARAMS_SVH
`define FIC_PARAMS_SVH

// ==========================================================
// Opcodes
`define FIC_OP_RELEASE 8'hAB
`define FIC_OP_MFR_ID 8'h90
`define FIC_OP_JEDEC_ID 8'h9F

// ==========================================================
// Clock and link timing
`define FIC_CLK_NS 40
`define FIC_SCK_HALF 10
`define FIC_ADDR_BITS 24
`define FIC_OP_BITS 8

// ==========================================================
// Release waits, least times, rounded up
`define FIC_RELEASE_WAIT_SHORT_NS 1000
`define FIC_RELEASE_WAIT_WITH_IDENT_NS 2000
`define FIC_RELEASE_WAIT_SHORT_CYC \
	((`FIC_RELEASE_WAIT_SHORT_NS + `FIC_CLK_NS - 1) / `FIC_CLK_NS)
`define FIC_RELEASE_WAIT_WITH_IDENT_CYC \
	((`FIC_RELEASE_WAIT_WITH_IDENT_NS + `FIC_CLK_NS - 1) / `FIC_CLK_NS)

// ==========================================================
// Power-up delays seen by the host
`define FIC_SUPPLY_TO_SELECT_DELAY_US 10
`define FIC_POWERUP_WRITE_DELAY_US 10000
`define FIC_SUPPLY_TO_SELECT_DELAY_CYC \
	((`FIC_SUPPLY_TO_SELECT_DELAY_US * 1000 + `FIC_CLK_NS - 1) / `FIC_CLK_NS)
`define FIC_POWERUP_WRITE_DELAY_CYC \
	((`FIC_POWERUP_WRITE_DELAY_US * 1000 + `FIC_CLK_NS - 1) / `FIC_CLK_NS)

`endif

// [verilog/fic_pkg.sv]
// Types shared by the device end and the host end of the identification link
package fic_pkg;

	typedef enum logic [1:0] {FIC_CMD_WAKE, FIC_CMD_DEV_ID, FIC_CMD_MFR_ID,
		FIC_CMD_JEDEC_ID} fic_cmd_t;

	typedef enum logic [1:0] {FIC_MODE_DEV_ID, FIC_MODE_MFR_ID,
		FIC_MODE_JEDEC_ID} fic_mode_t;

	typedef enum {FIC_DS_IDLE, FIC_DS_OPCODE, FIC_DS_ADDR, FIC_DS_SHIFT,
		FIC_DS_IGNORE} fic_dev_state_t;

	typedef enum {FIC_HS_POWERUP, FIC_HS_IDLE, FIC_HS_LEAD, FIC_HS_XFER,
		FIC_HS_TAIL, FIC_HS_GAP} fic_host_state_t;

endpackage
